// file: src/qubd_pkg.sv
// shared constants for the quad uart host bus decode block
package qubd_pkg;
    localparam int QUBD_CHANNELS = 4;
    localparam int QUBD_ADDR_W = 3;
    localparam int QUBD_DATA_W = 8;
    localparam int QUBD_CHAN_W = 2;
    localparam logic QUBD_STYLE_SPLIT = 1'b1;
    localparam logic QUBD_STYLE_DIR = 1'b0;
    localparam logic QUBD_STYLE_RESET = QUBD_STYLE_SPLIT;
    localparam logic [1:0] QUBD_SYNC_IDLE = 2'h3;
    localparam logic [3:0] QUBD_ALL_OFF = 4'h0;
    localparam logic [7:0] QUBD_DATA_ZERO = 8'h00;
    localparam logic [2:0] QUBD_ADDR_ZERO = 3'h0;
endpackage

// file: src/qubd_sync.sv
// three-stage synchroniser; a change counts once stages two and three agree
module qubd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    // per bit: move only when the two settled stages agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : out_q[g];
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            out_q <= INIT;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign o_sync = out_q;
endmodule // qubd_sync

// file: src/qubd_host_port.sv
// host parallel bus front end of a four-channel uart, two selectable bus styles
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - a high bus-style input gives the split-strobe style, a low one the direction-line style.
// - an undriven bus-style input reads as high, so split-strobe is the default.
// - in direction-line style the write pin is read/write, reset is active low, read pin ignored.
// - in direction-line style the four channel interrupts are wire-ORed onto one open-source irq.
// - three low address bits pick the register inside the addressed channel in both styles.
// - in direction-line style with chip select low, the two channel-address bits pick a channel.
// - in direction-line style a low common chip select enables all four channels as a group.
// - in split-strobe style channel_addr pins are chip selects two and three, common select is one.
// - in split-strobe style only the channel whose own chip select is low transfers data.
// - the data bus is eight bits, three-state, bit zero least significant.
// - in split-strobe style a low read strobe puts the addressed register on the data bus.
// - split style: irq_force_enable high keeps channel irq outputs on, else a modem bit gates.
module qubd_host_port
    import qubd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_bus_style,
    input wire logic i_reset_pin,
    input wire logic i_cs_n,
    input wire logic [QUBD_CHAN_W-1:0] i_channel_addr,
    input wire logic i_cs_d_n,
    input wire logic i_read_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic [QUBD_ADDR_W-1:0] i_addr,
    input wire logic [QUBD_DATA_W-1:0] i_data,
    input wire logic [QUBD_CHANNELS-1:0] i_chan_irq,
    input wire logic [QUBD_CHANNELS-1:0] i_modem_control_reg_irq_en,
    input wire logic i_irq_force_enable,
    input wire logic [QUBD_CHANNELS*QUBD_DATA_W-1:0] i_chan_rdata,
    output logic [QUBD_DATA_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_bus_style,
    output logic o_uart_reset,
    output logic [QUBD_CHANNELS-1:0] o_chan_rd,
    output logic [QUBD_CHANNELS-1:0] o_chan_wr,
    output logic [QUBD_ADDR_W-1:0] o_reg_addr,
    output logic [QUBD_DATA_W-1:0] o_wdata,
    output logic [QUBD_CHANNELS-1:0] o_chan_int,
    output logic [QUBD_CHANNELS-1:0] o_chan_int_oe,
    output logic o_irq_n,
    output logic o_irq_oe
);
    // positions of each pin in the synchronised control word
    localparam int PIN_WR = 0;
    localparam int PIN_RD = PIN_WR + 1;
    localparam int PIN_CS_D = PIN_RD + 1;
    localparam int PIN_CHAN = PIN_CS_D + 1;
    localparam int PIN_CS = PIN_CHAN + QUBD_CHAN_W;
    localparam int PIN_RESET = PIN_CS + 1;
    localparam int PIN_STYLE = PIN_RESET + 1;
    localparam int SYNC_W = PIN_STYLE + 1;
    // idle levels: style pulled up, reset pin quiet, selects and strobes high
    localparam logic [SYNC_W-1:0] PINS_IDLE = {QUBD_STYLE_SPLIT, 1'b0, 1'b1, QUBD_SYNC_IDLE,
                                               3'h7};

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; strobes and selects idle high, style pin pulled up
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [QUBD_ADDR_W-1:0] addr_s;
    logic [QUBD_DATA_W-1:0] data_s;

    // a floating style pin resolves high at the pad; sync init matches
    assign pins_raw = {i_bus_style, i_reset_pin, i_cs_n, i_channel_addr, i_cs_d_n,
                       i_read_strobe_n, i_write_strobe_n};

    qubd_sync #(.WIDTH(SYNC_W), .INIT(PINS_IDLE)) u_sync_ctl (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );
    qubd_sync #(.WIDTH(QUBD_ADDR_W), .INIT(QUBD_ADDR_ZERO)) u_sync_addr (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_addr),
        .o_sync(addr_s)
    );
    qubd_sync #(.WIDTH(QUBD_DATA_W), .INIT(QUBD_DATA_ZERO)) u_sync_data (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_data),
        .o_sync(data_s)
    );

    wire style_s = pins_s[PIN_STYLE];
    wire reset_pin_s = pins_s[PIN_RESET];
    wire cs_s_n = pins_s[PIN_CS];
    wire [QUBD_CHAN_W-1:0] chan_addr_s = pins_s[PIN_CHAN +: QUBD_CHAN_W];
    wire cs_d_s_n = pins_s[PIN_CS_D];
    wire rd_s_n = pins_s[PIN_RD];
    wire wr_s_n = pins_s[PIN_WR];

    ////////////////////////////////////////////////////////////////////////////
    // bus style and channel decode
    logic style_q;
    wire split = (style_q == QUBD_STYLE_SPLIT);

    // split style: each pin is its own channel select
    wire [QUBD_CHANNELS-1:0] sel_split = ~{cs_d_s_n, chan_addr_s[1], chan_addr_s[0], cs_s_n};
    // direction style: common select enables the group, address picks one
    wire [QUBD_CHANNELS-1:0] sel_dir = cs_s_n ? QUBD_ALL_OFF
                                     : (QUBD_CHANNELS'(1) << chan_addr_s);
    wire [QUBD_CHANNELS-1:0] sel = split ? sel_split : sel_dir;

    // a transfer is active while strobe and select are both asserted; a direction-style read needs only the select low with the write pin high
    // a strobe that leads its select still starts the access once the select arrives
    wire any_sel = |sel;
    wire rd_active = split ? (~rd_s_n & any_sel) : (~cs_s_n & wr_s_n);
    wire wr_active = split ? (~wr_s_n & any_sel) : (~cs_s_n & ~wr_s_n);

    // one-cycle strobes on the leading edge of each access
    logic rd_act_q;
    logic wr_act_q;
    wire rd_start = rd_active & ~rd_act_q;
    wire wr_start = wr_active & ~wr_act_q;

    // uart core reset follows the bus style's polarity
    wire uart_reset_d = split ? reset_pin_s : ~reset_pin_s;

    ////////////////////////////////////////////////////////////////////////////
    // read data select; every selected channel drives its lane, zero when nothing selected
    // selected lanes are or-ed; two selects low at once merge their data
    wire [QUBD_DATA_W-1:0] rdata_acc [0:QUBD_CHANNELS];
    wire [QUBD_DATA_W-1:0] rdata_mux = rdata_acc[QUBD_CHANNELS];
    assign rdata_acc[0] = QUBD_DATA_ZERO;
    genvar g;
    generate
        for (g = 0; g < QUBD_CHANNELS; g++) begin : g_chan
            wire [QUBD_DATA_W-1:0] lane = i_chan_rdata[g*QUBD_DATA_W +: QUBD_DATA_W];
            assign rdata_acc[g+1] = rdata_acc[g] | (sel[g] ? lane : QUBD_DATA_ZERO);
        end
    endgenerate
    wire drive_data = rd_active & (|sel);

    ////////////////////////////////////////////////////////////////////////////
    // interrupts
    // split style: per channel three-state pins, forced or gated by the modem control bit
    wire [QUBD_CHANNELS-1:0] int_oe_d = i_irq_force_enable ? {QUBD_CHANNELS{1'b1}}
                                        : i_modem_control_reg_irq_en;
    // direction style: open source, low when any channel asks, else released
    wire any_irq = |i_chan_irq;

    ////////////////////////////////////////////////////////////////////////////
    // style register; decode only ever sees a settled style
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            style_q <= QUBD_STYLE_RESET;
        end else begin
            style_q <= style_s;
        end
    end

    // previous activity, for leading-edge detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_active;
            wr_act_q <= wr_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access pulses towards the channels; a held strobe gives one pulse only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_chan_rd <= QUBD_ALL_OFF;
            o_chan_wr <= QUBD_ALL_OFF;
        end else begin
            o_chan_rd <= rd_start ? sel : QUBD_ALL_OFF;
            o_chan_wr <= wr_start ? sel : QUBD_ALL_OFF;
        end
    end

    // address and write data travel with the pulses
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_addr <= QUBD_ADDR_ZERO;
            o_wdata <= QUBD_DATA_ZERO;
        end else begin
            o_reg_addr <= addr_s;
            o_wdata <= data_s;
        end
    end

    // read data and its enable, held while the read stays active
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data <= QUBD_DATA_ZERO;
            o_data_oe <= 1'b0;
        end else begin
            o_data <= rdata_mux;
            o_data_oe <= drive_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // style shown outward and core reset, both from settled pins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bus_style <= QUBD_STYLE_RESET;
            o_uart_reset <= 1'b1;
        end else begin
            o_bus_style <= style_q;
            o_uart_reset <= uart_reset_d;
        end
    end

    // interrupt pins; the shared request only ever pulls low
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_chan_int <= QUBD_ALL_OFF;
            o_chan_int_oe <= QUBD_ALL_OFF;
            o_irq_n <= 1'b0;
            o_irq_oe <= 1'b0;
        end else begin
            o_chan_int <= i_chan_irq;
            o_chan_int_oe <= split ? int_oe_d : QUBD_ALL_OFF;
            o_irq_n <= 1'b0;
            o_irq_oe <= ~split & any_irq;
        end
    end
endmodule // qubd_host_port

// file: test/qubd_host_port_assertions.sv
// concurrent checks on the host bus decode ports
module qubd_host_port_checker
    import qubd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [QUBD_CHANNELS-1:0] i_chan_irq,
    input wire logic [QUBD_CHANNELS-1:0] i_modem_control_reg_irq_en,
    input wire logic i_irq_force_enable,
    input wire logic o_data_oe,
    input wire logic o_bus_style,
    input wire logic [QUBD_CHANNELS-1:0] o_chan_rd,
    input wire logic [QUBD_CHANNELS-1:0] o_chan_wr,
    input wire logic [QUBD_CHANNELS-1:0] o_chan_int_oe,
    input wire logic o_irq_n,
    input wire logic o_irq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rd_one_chan: assert property ($onehot0(o_chan_rd))
        else $error("read pulse on two channels");
    a_rd_single: assert property (|o_chan_rd |=> o_chan_rd == 4'h0)
        else $error("read pulse too long");
    a_wr_single: assert property (|o_chan_wr |=> o_chan_wr == 4'h0)
        else $error("write pulse too long");
    a_rd_drives_bus: assert property (|o_chan_rd |-> o_data_oe)
        else $error("read without bus drive");
    a_irq_pull_low: assert property (o_irq_n == 1'b0)
        else $error("irq drives high");
    a_irq_wired_or: assert property (!$past(i_rst) && !$past(o_bus_style) && !o_bus_style
        |-> o_irq_oe == $past(|i_chan_irq))
        else $error("irq not or of channels");
    a_irq_split_off: assert property (!$past(i_rst) && $past(o_bus_style) && o_bus_style
        |-> !o_irq_oe)
        else $error("irq driven in split style");
    a_int_gate: assert property (!$past(i_rst) && $past(o_bus_style) && o_bus_style
        |-> o_chan_int_oe == ($past(i_irq_force_enable) ? 4'hF
        : $past(i_modem_control_reg_irq_en)))
        else $error("channel int enable wrong");
endmodule // qubd_host_port_checker

bind qubd_host_port qubd_host_port_checker i_chk (.*);

// file: test/qubd_host_model.sv
// host processor model driving the parallel bus pins
module qubd_host_model (
    input wire logic i_clk,
    output logic o_cs_n,
    output logic [1:0] o_channel_addr,
    output logic o_cs_d_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_n,
    output logic [2:0] o_addr,
    output logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_cs_n, o_channel_addr, o_cs_d_n} = 4'hF;
        {o_read_strobe_n, o_write_strobe_n} = 2'h3;
        {o_addr, o_data} = 11'h000;
    end
    // held 8 cycles, past pin latency; idle 8 so the strobe is seen inactive
    task automatic access(input logic sp, sel, wr, input logic [1:0] c,
                          input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_data <= d;
        o_cs_n <= !(sel && (!sp || c == 2'h0));
        o_channel_addr <= sp ? {!(sel && c == 2'h2), !(sel && c == 2'h1)} : c;
        o_cs_d_n <= !(sp && sel && c == 2'h3);
        // in direction style the unused read pin is pulled low on purpose
        o_read_strobe_n <= sp && wr;
        o_write_strobe_n <= !wr;
        repeat (8) @(posedge i_clk);
        {o_cs_n, o_channel_addr, o_cs_d_n} <= 4'hF;
        {o_read_strobe_n, o_write_strobe_n} <= 2'h3;
        o_data <= ~d;
        repeat (8) @(posedge i_clk);
    endtask
endmodule // qubd_host_model

// file: test/qubd_host_port_tb.sv
// testbench for the host bus decode block
module qubd_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rst, i_bus_style, i_reset_pin, i_irq_force_enable;
    logic [3:0] i_chan_irq, mc_irq_en, o_chan_rd, o_chan_wr, o_chan_int, o_chan_int_oe, s_rd, s_wr;
    logic [31:0] i_chan_rdata;
    logic [7:0] o_data, o_wdata, s_d, s_q;
    logic [2:0] o_reg_addr, s_a;
    logic o_data_oe, o_bus_style, o_uart_reset, o_irq_n, o_irq_oe;
    wire logic cs_n, cs_d_n, rd_n, wr_n;
    wire logic [1:0] ch_a;
    wire logic [2:0] addr;
    wire logic [7:0] hd;
    int n_fail, checks, n_pulse, n_oe;
    qubd_host_model i_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_channel_addr(ch_a),
        .o_cs_d_n(cs_d_n), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_addr(addr),
        .o_data(hd));
    qubd_host_port i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus_style(i_bus_style),
        .i_reset_pin(i_reset_pin), .i_cs_n(cs_n), .i_channel_addr(ch_a), .i_cs_d_n(cs_d_n),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_addr(addr), .i_data(hd),
        .i_chan_irq(i_chan_irq), .i_modem_control_reg_irq_en(mc_irq_en),
        .i_irq_force_enable(i_irq_force_enable), .i_chan_rdata(i_chan_rdata),
        .o_data(o_data), .o_data_oe(o_data_oe), .o_bus_style(o_bus_style),
        .o_uart_reset(o_uart_reset), .o_chan_rd(o_chan_rd), .o_chan_wr(o_chan_wr),
        .o_reg_addr(o_reg_addr), .o_wdata(o_wdata), .o_chan_int(o_chan_int),
        .o_chan_int_oe(o_chan_int_oe), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_data_oe) n_oe++;
        if ((|o_chan_rd) || (|o_chan_wr)) begin
            {s_rd, s_wr, s_a, s_d, s_q} = {o_chan_rd, o_chan_wr, o_reg_addr, o_wdata, o_data};
            n_pulse++;
        end
    end
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic sp, sel, wr, input logic [1:0] c, input logic [2:0] a);
        logic [3:0] oh;
        oh = 4'h1 << c;
        n_pulse = 0;
        n_oe = 0;
        i_host.access(sp, sel, wr, c, a, {a, 3'h5, c});
        chk(n_pulse, sel);
        chk(n_oe != 0, sel && !wr);
        if (sel) chk({s_rd, s_wr, s_a, wr ? s_d : s_q},
            {wr ? 4'h0 : oh, wr ? oh : 4'h0, a, wr ? {a, 3'h5, c} : i_chan_rdata[c*8+:8]});
    endtask
    task automatic t_split;
        for (int c = 0; c < 4; c++) begin
            i_irq_force_enable <= c[0];
            xfer(1'b1, 1'b1, 1'b1, c[1:0], 3'(c + 1));
            xfer(1'b1, 1'b1, 1'b0, c[1:0], 3'(7 - c));
        end
        xfer(1'b1, 1'b0, 1'b0, 2'h0, 3'h3);
        i_irq_force_enable <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk({o_chan_int, o_chan_int_oe}, 8'h96);
        i_irq_force_enable <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({o_chan_int, o_chan_int_oe}, 8'h9F);
        $display("split style test done");
    endtask
    task automatic t_dir;
        i_bus_style <= 1'b0;
        i_reset_pin <= 1'b1;
        repeat (12) @(posedge i_clk);
        chk({o_bus_style, o_uart_reset}, 2'h0);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b0, 1'b1, 1'b1, c[1:0], 3'(c));
            xfer(1'b0, 1'b1, 1'b0, c[1:0], 3'(6 - c));
        end
        xfer(1'b0, 1'b0, 1'b1, 2'h1, 3'h2);
        i_chan_irq <= 4'h4;
        repeat (3) @(posedge i_clk);
        chk(o_irq_oe, 1'b1);
        i_chan_irq <= 4'h0;
        repeat (3) @(posedge i_clk);
        chk(o_irq_oe, 1'b0);
        i_chan_irq <= 4'h9;
        i_reset_pin <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk(o_uart_reset, 1'b1);
        i_bus_style <= 1'b1;
        repeat (12) @(posedge i_clk);
        chk({o_bus_style, o_uart_reset}, 2'h2);
        $display("direction style test done");
    endtask
    task automatic report_and_stop;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {i_rst, i_bus_style, i_reset_pin, i_irq_force_enable} = 4'hC;
        {i_chan_irq, mc_irq_en, i_chan_rdata} = {8'h96, 32'hC3B2A190};
        {n_fail, checks} = 0;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk(o_bus_style, 1'b1);
        t_split;
        t_dir;
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        n_fail++;
        report_and_stop;
    end
endmodule // qubd_host_port_tb
